//--- common/hpd_regs.vh
`ifndef HPD_REGS_VH
`define HPD_REGS_VH
// register indices as printed; byte address is four times the index
`define HPD_IDX_BUS_DIS_MASK 8'h0b
`define HPD_IDX_MAXP_SP 8'h0c
`define HPD_IDX_MAXP_BP 8'h0d
`define HPD_IDX_HC_MAXC_SP 8'h0e
`define HPD_IDX_HC_MAXP_BP 8'h0f
// control register holding the remap select and operating mode bits
`define HPD_IDX_CTRL 8'h10
// status register showing effective port map
`define HPD_IDX_STATUS 8'h11
// field positions
`define HPD_PORT1_BIT 1
`define HPD_PORT2_BIT 2
`define HPD_CTRL_REMAP_BIT 0
`define HPD_CTRL_BUSPWR_BIT 1
`define HPD_CTRL_DEFCFG_BIT 2
// reset values
`define HPD_RST_BYTE 8'h00
`define HPD_RST_CTRL 8'h00
`endif

//--- rtl/hpd_port_map.v
`timescale 1ns/1ps
`include "hpd_regs.vh"
// combines disable sources into port count and logical numbering
module hpd_port_map (
  input wire [7:0] disableMask,
  input wire [1:0] strapsSync,
  input wire useStraps,
  input wire remapSelect,
  output reg [1:0] portEnable,
  output reg [1:0] portCount,
  output reg [1:0] logicalPort1,
  output reg [1:0] logicalPort2
);
  reg [1:0] dis;
  // only bits 2 and 1 matter; reserved bits never reach the map
  always @* begin
    dis = useStraps ? strapsSync :
      {disableMask[`HPD_PORT2_BIT], disableMask[`HPD_PORT1_BIT]};
    // explicit remap mode leaves disabling to the remap register elsewhere
    if (remapSelect) begin
      dis = 2'h0;
    end
    portEnable = ~dis;
    portCount = {1'b0, ~dis[0]} + {1'b0, ~dis[1]};
    logicalPort1 = dis[0] ? 2'h0 : 2'h1;
    // port 2 slides down to number 1 when port 1 is hidden
    logicalPort2 = dis[1] ? 2'h0 : (dis[0] ? 2'h1 : 2'h2);
  end
endmodule // hpd_port_map

//--- rtl/hpd_config_regs.v
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "hpd_regs.vh"
module hpd_config_regs (
  input wire clk,
  input wire arst_n,
  input wire clkEn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [1:0] portDisableStraps,
  output reg [1:0] portEnable_q,
  output reg [1:0] portCount_q,
  output reg [1:0] logicalPort1_q,
  output reg [1:0] logicalPort2_q,
  output reg [7:0] selfPoweredBudget_q,
  output reg [7:0] busPoweredBudget_q,
  output reg [7:0] controllerSelfPoweredCurrent_q,
  output reg [7:0] controllerBusPoweredBudget_q,
  output reg portRemapSelect_q
);
  // clkEn low freezes every flop below, the answer included; a master that
  // keeps its access phase up simply sees pready later

  // stored configuration bytes that are not also outputs
  reg [7:0] busPoweredDisableMask_q;
  reg [7:0] ctrl_q;

  // two-stage synchroniser for the strap pins
  reg [1:0] strapMeta_q;
  reg [1:0] strapSync_q;

  // bus answer sequencer, one-hot so a upset shows as an illegal code
  localparam ST_IDLE = 2'h1;
  localparam ST_ANSWER = 2'h2;
  reg [1:0] apbState_q;
  reg [1:0] apbState_d;

  // read data and decode verdict, settled before the answer edge
  reg [31:0] rdata_d;
  reg addrOk;

  // address pieces
  wire [9:0] wordIdx;
  wire [7:0] regIdx;
  wire alignOk;
  wire pageOk;

  // transfer qualifiers
  wire access;
  wire wrStrobe;
  wire rdStrobe;

  // one select line per register
  wire selMask;
  wire selSelfPower;
  wire selBusPower;
  wire selCtrlSelfCurrent;
  wire selCtrlBusPower;
  wire selCtrl;
  wire selStatus;
  wire anySel;

  // control fields
  wire remapSel;
  wire busMode;
  wire defCfg;
  wire [7:0] maskForMap;

  // combinational port map, registered below
  wire [1:0] mapEnable;
  wire [1:0] mapCount;
  wire [1:0] mapLog1;
  wire [1:0] mapLog2;
  wire [7:0] statusByte;

  // byte address to word index; only aligned words of the low page exist
  assign wordIdx = paddr[11:2];
  assign regIdx = wordIdx[7:0];
  assign alignOk = (paddr[1:0] == 2'h0);
  assign pageOk = (wordIdx[9:8] == 2'h0);

  // register selects, one per index
  assign selMask = (regIdx == `HPD_IDX_BUS_DIS_MASK);
  assign selSelfPower = (regIdx == `HPD_IDX_MAXP_SP);
  assign selBusPower = (regIdx == `HPD_IDX_MAXP_BP);
  assign selCtrlSelfCurrent = (regIdx == `HPD_IDX_HC_MAXC_SP);
  assign selCtrlBusPower = (regIdx == `HPD_IDX_HC_MAXP_BP);
  assign selCtrl = (regIdx == `HPD_IDX_CTRL);
  assign selStatus = (regIdx == `HPD_IDX_STATUS);
  // status answers reads only; writes to it are quietly dropped
  assign anySel = selMask | selSelfPower | selBusPower | selCtrlSelfCurrent |
    selCtrlBusPower | selCtrl | selStatus;

  // a request is taken only from idle, so a held access phase is answered every second cycle
  assign access = psel & penable & (apbState_q == ST_IDLE);
  // writes land with the answer; a refused address changes nothing
  assign wrStrobe = access & pwrite & addrOk;
  assign rdStrobe = access & ~pwrite;

  // control register fields
  assign remapSel = ctrl_q[`HPD_CTRL_REMAP_BIT];
  assign busMode = ctrl_q[`HPD_CTRL_BUSPWR_BIT];
  assign defCfg = ctrl_q[`HPD_CTRL_DEFCFG_BIT];

  // the mask only rules in bus-powered mode; the self-powered mask lives elsewhere
  assign maskForMap = busMode ? busPoweredDisableMask_q : `HPD_RST_BYTE;

  // status packs the registered map, so it trails a mask write by one cycle
  assign statusByte = {logicalPort2_q, logicalPort1_q, portCount_q, portEnable_q};

  // straps come from pins, so two flops before use
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strapMeta_q <= 2'h0;
      strapSync_q <= 2'h0;
    end else if (clkEn) begin
      strapMeta_q <= portDisableStraps;
      strapSync_q <= strapMeta_q;
    end
  end

  // next answer state: one answer per access phase, then back to idle
  always @* begin
    apbState_d = ST_IDLE;
    case (apbState_q)
      ST_IDLE: begin
        // one wait state: the request edge moves us to the answer
        if (access) begin
          apbState_d = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        // the master releases after seeing pready, so go straight back
        apbState_d = ST_IDLE;
      end
      default: begin
        apbState_d = ST_IDLE;
      end
    endcase
  end

  // answer state register
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      apbState_q <= ST_IDLE;
    end else if (clkEn) begin
      apbState_q <= apbState_d;
    end
  end

  // read mux; refused addresses read as zero
  always @* begin
    addrOk = alignOk & pageOk & anySel;
    rdata_d = 32'h0;
    if (!addrOk) begin
      rdata_d = 32'h0;
    end else if (selMask) begin
      rdata_d = {24'h0, busPoweredDisableMask_q};
    end else if (selSelfPower) begin
      rdata_d = {24'h0, selfPoweredBudget_q};
    end else if (selBusPower) begin
      rdata_d = {24'h0, busPoweredBudget_q};
    end else if (selCtrlSelfCurrent) begin
      rdata_d = {24'h0, controllerSelfPoweredCurrent_q};
    end else if (selCtrlBusPower) begin
      rdata_d = {24'h0, controllerBusPoweredBudget_q};
    end else if (selCtrl) begin
      rdata_d = {24'h0, ctrl_q};
    end else begin
      rdata_d = {24'h0, statusByte};
    end
  end

  // bus answer: all three outputs stand for one cycle only
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0;
      pready <= 1'h0;
      pslverr <= 1'h0;
    end else if (clkEn) begin
      pready <= access;
      pslverr <= access & ~addrOk;
      // data bus idles at zero so stale values never leak between reads
      prdata <= rdStrobe ? rdata_d : 32'h0;
    end
  end

  // bus-powered disable mask; reserved bits kept so software reads back its value
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busPoweredDisableMask_q <= `HPD_RST_BYTE;
    end else if (clkEn && wrStrobe && selMask) begin
      busPoweredDisableMask_q <= pwdata[7:0];
    end
  end

  // budget bytes are plain storage; the hub reports them upstream as written
  // self-powered power budget
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selfPoweredBudget_q <= `HPD_RST_BYTE;
    end else if (clkEn && wrStrobe && selSelfPower) begin
      selfPoweredBudget_q <= pwdata[7:0];
    end
  end

  // bus-powered power budget
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busPoweredBudget_q <= `HPD_RST_BYTE;
    end else if (clkEn && wrStrobe && selBusPower) begin
      busPoweredBudget_q <= pwdata[7:0];
    end
  end

  // controller self-powered current; no range check, software keeps it legal
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      controllerSelfPoweredCurrent_q <= `HPD_RST_BYTE;
    end else if (clkEn && wrStrobe && selCtrlSelfCurrent) begin
      controllerSelfPoweredCurrent_q <= pwdata[7:0];
    end
  end

  // controller bus-powered budget, without any compound peripheral
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      controllerBusPoweredBudget_q <= `HPD_RST_BYTE;
    end else if (clkEn && wrStrobe && selCtrlBusPower) begin
      controllerBusPoweredBudget_q <= pwdata[7:0];
    end
  end

  // control: only the three defined bits are stored, the rest read zero
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `HPD_RST_CTRL;
    end else if (clkEn && wrStrobe && selCtrl) begin
      ctrl_q <= {5'h0, pwdata[2:0]};
    end
  end

  // disable sources folded into count and numbering
  hpd_port_map uMap (
    .disableMask(maskForMap),
    .strapsSync(strapSync_q),
    .useStraps(defCfg),
    .remapSelect(remapSel),
    .portEnable(mapEnable),
    .portCount(mapCount),
    .logicalPort1(mapLog1),
    .logicalPort2(mapLog2)
  );

  // registered port map outputs, one cycle behind configuration
  // reset shows both ports enabled, matching the all-zero mask
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      portEnable_q <= 2'h3;
      portCount_q <= 2'h2;
      logicalPort1_q <= 2'h1;
      logicalPort2_q <= 2'h2;
      portRemapSelect_q <= 1'h0;
    end else if (clkEn) begin
      portEnable_q <= mapEnable;
      portCount_q <= mapCount;
      logicalPort1_q <= mapLog1;
      logicalPort2_q <= mapLog2;
      portRemapSelect_q <= remapSel;
    end
  end
endmodule // hpd_config_regs

//--- sim/hpd_host_model.sv
`timescale 1ns/1ps
// upstream host: which reported port numbers it enumerates
module hpd_host_model (
  input wire logic [1:0] logicalPort1_q,
  input wire logic [1:0] logicalPort2_q,
  output logic [1:0] seen
);
  // number 0 means hidden, never enumerated
  assign seen = 2'(((3'h1 << logicalPort1_q) | (3'h1 << logicalPort2_q)) >> 1);
endmodule // hpd_host_model

//--- sim/hpd_checker.sv
`timescale 1ns/1ps
module hpd_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] portEnable_q,
  input wire logic [1:0] portCount_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // one wait state, then a single-cycle answer
  a_ready_wait: assert property (psel && penable && !pready && clkEn |=> pready)
    else $error("late pready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("long pready");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("stray pslverr");
  a_bad_align: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned accepted");
  a_good_addr: assert property (pready && paddr[1:0] == 2'h0 && paddr >= 12'h2c &&
    paddr <= 12'h44 |-> !pslverr)
    else $error("mapped refused");
  a_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("prdata outside answer");
  a_count_match: assert property (portCount_q == 2'(portEnable_q[0] + portEnable_q[1]))
    else $error("count off");
  a_reset_map: assert property ($rose(arst_n) |-> portEnable_q == 2'h3 && portCount_q == 2'h2)
    else $error("reset map");
  c_err: cover property (pslverr);
  c_none: cover property (portCount_q == 2'h0);
  c_one: cover property (portCount_q == 2'h1);
endmodule // hpd_checker
bind hpd_config_regs hpd_checker u_hpd_checker (.*);

//--- sim/hub_port_disable_power_config_test.sv
`timescale 1ns/1ps
module hub_port_disable_power_config_test;
  logic clk = 1'h0, arst_n = 1'h0, clkEn = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, v;
  logic pready, pslverr, portRemapSelect_q, er;
  logic [1:0] portDisableStraps = '0, portEnable_q, portCount_q, logicalPort1_q, logicalPort2_q;
  logic [1:0] seen;
  wire [7:0] mapNow = {logicalPort2_q, logicalPort1_q, portCount_q, portEnable_q};
  logic [7:0] selfPoweredBudget_q, busPoweredBudget_q, controllerSelfPoweredCurrent_q, e;
  logic [7:0] controllerBusPoweredBudget_q, bud [1:4];
  int nErrors = 0, numChecks = 0;
  hpd_config_regs u_hpd_config_regs (.*);
  hpd_host_model u_hpd_host_model (.*);
  initial forever #50 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    numChecks++;
    if (s !== x) begin
      nErrors++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic closeOut;
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    i = 0;
    do @(posedge clk); while (pready !== 1'h1 && ++i < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    if (i >= 20) begin
      nErrors++;
      closeOut;
    end
  endtask
  // packs {log2, log1, count, enable} from the disable pair
  function automatic logic [7:0] expMap(input logic [1:0] dis);
    logic [1:0] en;
    en = ~dis;
    return {en[1] ? (en[0] ? 2'h2 : 2'h1) : 2'h0, 1'h0, en[0], 2'(en[0] + en[1]), en};
  endfunction
  initial begin
    int k;
    v = $urandom(32'h1612fc8c);
    repeat (8) @(posedge clk);
    arst_n <= 1'h1;
    for (k = 0; k < 5; k++) begin
      apb(1'h0, 12'h2c + 12'(4 * k), '0);
      chk("reset", rd, '0);
    end
    // junk in the upper bits must be dropped
    for (k = 1; k < 5; k++) begin
      v = $urandom;
      // self-powered values stay at or under 100 mA, i.e. 50 units
      if (k == 1 || k == 3) v[7:0] = 8'(v[7:0] % 51);
      bud[k] = v[7:0];
      apb(1'h1, 12'h2c + 12'(4 * k), v); // one budget or current byte per pass
      apb(1'h0, 12'h2c + 12'(4 * k), '0);
      chk("budget", rd, {24'h0, bud[k]});
    end
    chk("budgets", {controllerBusPoweredBudget_q, controllerSelfPoweredCurrent_q,
      busPoweredBudget_q, selfPoweredBudget_q}, {bud[4], bud[3], bud[2], bud[1]});
    apb(1'h1, 12'h40, 32'h2);
    for (k = 0; k < 8; k++) begin
      v = $urandom;
      if (k < 4) v[2:1] = 2'(k);
      e = expMap(v[2:1]);
      apb(1'h1, 12'h2c, v);
      apb(1'h0, 12'h2c, '0);
      chk("mask", rd, {24'h0, v[7:0]});
      apb(1'h0, 12'h44, '0);
      chk("status", rd, {24'h0, e});
      chk("ports", {mapNow, seen}, {e, e[3], |e[3:2]});
    end
    apb(1'h1, 12'h40, 32'h3);
    apb(1'h0, 12'h44, '0);
    chk("remap", {portRemapSelect_q, rd[7:0]}, {1'h1, expMap(2'h0)});
    apb(1'h1, 12'h2e, 32'hff);
    chk("misaligned", er, 1'h1);
    apb(1'h0, 12'h48, '0);
    chk("unmapped", {er, rd[7:0]}, 9'h100);
    apb(1'h1, 12'h40, 32'h4);
    for (k = 0; k < 4; k++) begin
      portDisableStraps <= 2'(k);
      repeat (4) @(posedge clk);
      chk("straps", mapNow, expMap(2'(k)));
    end
    // a low clock enable must freeze the map while the straps move
    clkEn <= 1'h0;
    portDisableStraps <= 2'h0;
    repeat (4) @(posedge clk);
    chk("frozen", mapNow, expMap(2'h3));
    clkEn <= 1'h1;
    repeat (4) @(posedge clk);
    chk("thawed", mapNow, expMap(2'h0));
    closeOut;
  end
endmodule // hub_port_disable_power_config_test
